/* File: logic/phy_specific_config_bits.sv */
// lower bits of the phy-specific configuration register and the logic
// they steer: duplex led select, automatic low power, state machine
// reset, preamble suppression, sleep and remote loop-out.
// assumes a management master on a plain address/strobe port, all
// inputs synchronous to ref_clk.
`timescale 1ns/1ps
module phy_specific_config_bits #(
  parameter int IDLE_CYCLES  = phy_cfg_pkg::LOW_PWR_IDLE_CYCLES,
  parameter int RESET_CYCLES = phy_cfg_pkg::SM_RESET_CYCLES,
  parameter int DATA_W       = phy_cfg_pkg::RX_DATA_W
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic [4:0]        reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [15:0]       reg_rdata,
  input  wire logic              full_duplex,
  input  wire logic              collision,
  input  wire logic              line_energy_detect,
  input  wire logic [DATA_W-1:0] rx_data,
  input  wire logic              rx_valid,
  output logic                   duplex_collision_led_output,
  output logic                   reduced_power_active,
  output logic                   mgmt_preamble_suppress,
  output logic                   sleep_power_down,
  output logic                   state_machine_reset,
  output logic                   remote_loop_out,
  output logic      [DATA_W-1:0] loop_tx_data,
  output logic                   loop_tx_valid,
  output logic      [DATA_W-1:0] mac_rx_data,
  output logic                   mac_rx_valid
);

  localparam int CW = $clog2(IDLE_CYCLES + 1);

  generate
    if (IDLE_CYCLES < 2 || RESET_CYCLES < 1 || DATA_W < 1)
    begin : g_bad
      $error("phy_specific_config_bits: unsupported parameters");
    end
  endgenerate

  typedef enum logic [1:0] {
    LP_RUN,
    LP_WAIT,
    LP_LOW
  } lp_state_t;

  typedef struct packed {
    logic              led_sel;
    logic              low_pwr_en;
    logic              sm_reset;
    logic              preamble_sup;
    logic              sleep;
    logic              loop_out;
    lp_state_t         lp_state;
    logic [CW-1:0]     idle_cnt;
    logic [15:0]       rdata;
    logic              led;
    logic              low_pwr;
    logic [DATA_W-1:0] loop_data;
    logic              loop_valid;
    logic [DATA_W-1:0] mac_data;
    logic              mac_valid;
  } cfg_state_t;

  cfg_state_t s_q;
  cfg_state_t s_d;

  logic seq_start;
  logic seq_busy;
  logic seq_done;
  logic cfg_wr;

  // register image as software reads it; upper bits read as zero
  function automatic logic [15:0] reg_image(input cfg_state_t s);
    logic [15:0] v;
    v = 16'h0000;
    v[phy_cfg_pkg::LED_SEL_BIT]      = s.led_sel;
    v[phy_cfg_pkg::LOW_PWR_EN_BIT]   = s.low_pwr_en;
    v[phy_cfg_pkg::SM_RESET_BIT]     = s.sm_reset;
    v[phy_cfg_pkg::PREAMBLE_SUP_BIT] = s.preamble_sup;
    v[phy_cfg_pkg::SLEEP_BIT]        = s.sleep;
    v[phy_cfg_pkg::LOOP_OUT_BIT]     = s.loop_out;
    return v;
  endfunction

  // address match shared by write and read decode, so both stay in step
  function automatic logic is_cfg_addr(input logic [4:0] a);
    return a == phy_cfg_pkg::CFG_REG_ADDR;
  endfunction

  // address decode of the one register this block owns
  assign cfg_wr = reg_wr && is_cfg_addr(reg_addr);

  // reset pulse on a 1 written to the reset bit, or on wake from sleep
  assign seq_start = cfg_wr &&
    (reg_wdata[phy_cfg_pkg::SM_RESET_BIT] ||
     (s_q.sleep && !reg_wdata[phy_cfg_pkg::SLEEP_BIT]));

  sm_reset_sequencer #(
    .CYCLES (RESET_CYCLES)
  ) u_seq (
    .ref_clk (ref_clk),
    .rst     (rst),
    .start   (seq_start),
    .busy    (seq_busy),
    .done    (seq_done)
  );

  // next-state logic for the whole block
  always_comb
  begin
    s_d = s_q;

    // register writes; configuration survives sleep untouched
    if (cfg_wr)
    begin
      s_d.led_sel      = reg_wdata[phy_cfg_pkg::LED_SEL_BIT];
      s_d.low_pwr_en   = reg_wdata[phy_cfg_pkg::LOW_PWR_EN_BIT];
      s_d.preamble_sup = reg_wdata[phy_cfg_pkg::PREAMBLE_SUP_BIT];
      s_d.sleep        = reg_wdata[phy_cfg_pkg::SLEEP_BIT];
      s_d.loop_out     = reg_wdata[phy_cfg_pkg::LOOP_OUT_BIT];
    end

    // self-clearing reset bit; a new request in the done cycle wins
    if (seq_done)
      s_d.sm_reset = 1'b0;
    if (cfg_wr && reg_wdata[phy_cfg_pkg::SM_RESET_BIT])
      s_d.sm_reset = 1'b1;

    // read data stands only in the cycle after the read strobe
    s_d.rdata = 16'h0000;
    if (reg_rd && is_cfg_addr(reg_addr))
      s_d.rdata = reg_image(s_q);

    // led select; dark while asleep since the driver is powered down
    if (s_q.sleep)
      s_d.led = 1'b0;
    else if (s_q.led_sel)
      s_d.led = full_duplex | collision;
    else
      s_d.led = full_duplex;

    // automatic low power on a quiet line, gated by its enable
    case (s_q.lp_state)
      LP_RUN:
      begin
        s_d.idle_cnt = '0;
        if (s_q.low_pwr_en && !line_energy_detect)
          s_d.lp_state = LP_WAIT;
      end
      LP_WAIT:
      begin
        if (!s_q.low_pwr_en || line_energy_detect)
          s_d.lp_state = LP_RUN;
        else if (s_q.idle_cnt == CW'(IDLE_CYCLES - 2))
          s_d.lp_state = LP_LOW;
        else
          s_d.idle_cnt = s_q.idle_cnt + CW'(1);
      end
      LP_LOW:
      begin
        if (!s_q.low_pwr_en || line_energy_detect)
          s_d.lp_state = LP_RUN;
      end
      default:
      begin
        s_d.lp_state = LP_RUN;
      end
    endcase

    // state machine reset and sleep both hold the fsm at its start
    if (seq_busy || s_q.sleep)
    begin
      s_d.lp_state = LP_RUN;
      s_d.idle_cnt = '0;
    end
    s_d.low_pwr = (s_d.lp_state == LP_LOW);

    // receive path: either looped out or handed to the mac, never both
    s_d.loop_data  = '0;
    s_d.loop_valid = 1'b0;
    s_d.mac_data   = '0;
    s_d.mac_valid  = 1'b0;
    if (!s_q.sleep && !seq_busy)
    begin
      if (s_q.loop_out)
      begin
        s_d.loop_data  = rx_data;
        s_d.loop_valid = rx_valid;
      end
      else
      begin
        s_d.mac_data  = rx_data;
        s_d.mac_valid = rx_valid;
      end
    end
  end

  // state register; only constants under reset
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s_q              <= '0;
      s_q.led_sel      <= phy_cfg_pkg::LED_SEL_RST;
      s_q.low_pwr_en   <= phy_cfg_pkg::LOW_PWR_EN_RST;
      s_q.sm_reset     <= phy_cfg_pkg::SM_RESET_RST;
      s_q.preamble_sup <= phy_cfg_pkg::PREAMBLE_SUP_RST;
      s_q.sleep        <= phy_cfg_pkg::SLEEP_RST;
      s_q.loop_out     <= phy_cfg_pkg::LOOP_OUT_RST;
      s_q.lp_state     <= LP_RUN;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register; state_machine_reset comes from the sequencer's busy flag
  assign reg_rdata                   = s_q.rdata;
  assign duplex_collision_led_output = s_q.led;
  assign reduced_power_active        = s_q.low_pwr;
  assign mgmt_preamble_suppress      = s_q.preamble_sup;
  assign sleep_power_down            = s_q.sleep;
  assign state_machine_reset         = seq_busy;
  assign remote_loop_out             = s_q.loop_out;
  assign loop_tx_data                = s_q.loop_data;
  assign loop_tx_valid               = s_q.loop_valid;
  assign mac_rx_data                 = s_q.mac_data;
  assign mac_rx_valid                = s_q.mac_valid;

endmodule

/* File: logic/phy_cfg_pkg.sv */
// constants for the vendor-specific configuration bits of a 10/100 phy
// assumes a 100 MHz ref_clk and a 5-bit management register address
package phy_cfg_pkg;

  // register map
  localparam logic [4:0]  CFG_REG_ADDR     = 5'h10;
  localparam int          REG_W            = 16;

  // field positions inside the configuration register
  localparam int          LED_SEL_BIT      = 5;
  localparam int          LOW_PWR_EN_BIT   = 4;
  localparam int          SM_RESET_BIT     = 3;
  localparam int          PREAMBLE_SUP_BIT = 2;
  localparam int          SLEEP_BIT        = 1;
  localparam int          LOOP_OUT_BIT     = 0;

  // reset values of the fields
  localparam logic        LED_SEL_RST      = 1'b0;
  localparam logic        LOW_PWR_EN_RST   = 1'b1;
  localparam logic        SM_RESET_RST     = 1'b0;
  localparam logic        PREAMBLE_SUP_RST = 1'b1;
  localparam logic        SLEEP_RST        = 1'b0;
  localparam logic        LOOP_OUT_RST     = 1'b0;

  // timing
  localparam int          CLK_PERIOD_NS    = 10;
  localparam int          SM_RESET_TIME_NS = 100;
  localparam int          LOW_PWR_IDLE_NS  = 10000;
  localparam int          SM_RESET_CYCLES  =
    (SM_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          LOW_PWR_IDLE_CYCLES =
    (LOW_PWR_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // receive nibble width on the mii side
  localparam int          RX_DATA_W        = 4;

endpackage

/* File: logic/sm_reset_sequencer.sv */
// timed reset pulse for the internal state machines
// assumes start is a one-cycle pulse in the ref_clk domain
`timescale 1ns/1ps
module sm_reset_sequencer #(
  parameter int CYCLES = phy_cfg_pkg::SM_RESET_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  localparam int CW = $clog2(CYCLES + 1);

  generate
    if (CYCLES < 1)
    begin : g_bad
      $error("sm_reset_sequencer needs at least one cycle");
    end
  endgenerate

  typedef struct packed {
    logic          busy;
    logic          done;
    logic [CW-1:0] cnt;
  } seq_state_t;

  seq_state_t s_q;
  seq_state_t s_d;

  // a start while busy restarts the count, so a late request is honoured
  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (start)
    begin
      s_d.busy = 1'b1;
      s_d.cnt  = CW'(CYCLES - 1);
    end
    else if (s_q.busy)
    begin
      if (s_q.cnt == '0)
      begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end
      else
      begin
        s_d.cnt = s_q.cnt - CW'(1);
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign busy = s_q.busy;
  assign done = s_q.done;

endmodule

/* File: sim/phy_cfg_props.sv */
// checker for the configuration bits, bound to the top module
// assumes one clock domain, ports as declared by the top module
`timescale 1ns/1ps
module phy_cfg_props (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [4:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        full_duplex,
  input wire logic        collision,
  input wire logic        line_energy_detect,
  input wire logic        duplex_collision_led_output,
  input wire logic        reduced_power_active,
  input wire logic        mgmt_preamble_suppress,
  input wire logic        sleep_power_down,
  input wire logic        state_machine_reset,
  input wire logic        remote_loop_out,
  input wire logic        loop_tx_valid,
  input wire logic        mac_rx_valid
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // write to the one mapped register
  sequence cfg_wr;
    reg_wr && reg_addr == 5'h10;
  endsequence
  // two cycles asleep, past the previous-cycle gating
  sequence asleep;
    sleep_power_down && $past(sleep_power_down);
  endsequence
  a_led_duplex: assert property (!$past(rst) && !$past(sleep_power_down)
    && !sleep_power_down && $past(full_duplex) |->
    duplex_collision_led_output) else $error("led lost duplex");
  a_led_off: assert property (!$past(rst) && !$past(full_duplex)
    && !$past(collision) |-> !duplex_collision_led_output)
    else $error("led lit with no status");
  a_led_asleep: assert property (asleep |->
    !duplex_collision_led_output) else $error("led lit asleep");
  a_energy_run: assert property (line_energy_detect |=>
    !reduced_power_active) else $error("low power with energy");
  a_sm_start: assert property (cfg_wr ##0 reg_wdata[3] |=>
    state_machine_reset) else $error("no fsm reset");
  a_pre_follow: assert property (cfg_wr |=>
    mgmt_preamble_suppress == $past(reg_wdata[2])) else $error("preamble");
  a_sleep_gate: assert property (asleep |->
    !mac_rx_valid && !loop_tx_valid) else $error("rx while asleep");
  a_wake_reset: assert property ($fell(sleep_power_down) |->
    ##[0:2] state_machine_reset) else $error("wake without reset");
  a_loop_route: assert property (remote_loop_out &&
    $past(remote_loop_out) |-> !mac_rx_valid) else $error("loop leak");
  a_unmapped_rd: assert property (reg_rd && reg_addr != 5'h10 |=>
    reg_rdata == 16'h0000) else $error("unmapped read not zero");
endmodule

bind phy_specific_config_bits phy_cfg_props u_props (.ref_clk, .rst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .full_duplex,
  .collision,
  .line_energy_detect, .duplex_collision_led_output, .reduced_power_active,
  .mgmt_preamble_suppress, .sleep_power_down, .state_machine_reset,
  .remote_loop_out, .loop_tx_valid, .mac_rx_valid);

/* File: sim/rx_source.sv */
// receive nibble source standing in for the line side
// assumes rst high from time zero and a seeded random stream
`timescale 1ns/1ps
module rx_source (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  output logic      [3:0] rx_data,
  output logic            rx_valid
);
  // fresh values each cycle, so a stale nibble matches only when two random draws agree
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_data  <= 4'h0;
      rx_valid <= 1'b0;
    end
    else
    begin
      rx_data  <= 4'($urandom);
      rx_valid <= 1'($urandom);
    end
  end
endmodule

/* File: sim/phy_specific_config_bits_bench.sv */
// bench for the configuration bits: register port, status, rx paths
// assumes small idle and reset counts so the run stays short
`timescale 1ns/1ps
module phy_specific_config_bits_bench;
  logic        ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [4:0]  reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic        full_duplex = 1'b0, collision = 1'b0, energy = 1'b1;
  logic [3:0]  rx_data, loop_d, mac_d, d;
  logic        rx_valid, led, rpa, pre, slp, smr, lo, loop_v, mac_v, v;
  logic        rd_pend = 1'b0;
  logic [15:0] exp_q[$];
  int          miscompares = 0, checked = 0;

  rx_source src (.ref_clk(ref_clk), .rst(rst), .rx_data(rx_data),
    .rx_valid(rx_valid));
  phy_specific_config_bits #(.IDLE_CYCLES(4), .RESET_CYCLES(8)) DUT (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .full_duplex(full_duplex),
    .collision(collision), .line_energy_detect(energy),
    .rx_data(rx_data), .rx_valid(rx_valid),
    .duplex_collision_led_output(led), .reduced_power_active(rpa),
    .mgmt_preamble_suppress(pre), .sleep_power_down(slp),
    .state_machine_reset(smr), .remote_loop_out(lo),
    .loop_tx_data(loop_d), .loop_tx_valid(loop_v),
    .mac_rx_data(mac_d), .mac_rx_valid(mac_v));

  always #5 ref_clk = ~ref_clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("miscompares %0d checked %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] dat);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= dat;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // the expected word is queued before the strobe goes out
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    exp_q.push_back(exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask

  // bounded wait; running out counts as a mismatch and ends the run
  task automatic wait_sig(ref logic s, input logic val);
    int n;
    for (n = 0; n < 2000 && s !== val; n++)
      @(posedge ref_clk);
    if (s !== val)
    begin
      miscompares++;
      print_verdict();
    end
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge ref_clk)
  begin
    if (rd_pend)
      chk(reg_rdata, exp_q.pop_front());
    rd_pend <= reg_rd;
  end

  initial
  begin
    void'($urandom(73456));
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    rd(5'h10, 16'h0014);
    rd(5'h03, 16'h0000);
    collision <= 1'b1;
    wr(5'h10, 16'h0030);
    repeat (3) @(posedge ref_clk);
    chk(led, 1'b1);
    wr(5'h10, 16'h0010);
    repeat (3) @(posedge ref_clk);
    chk(led, 1'b0);
    full_duplex <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(led, 1'b1);
    full_duplex <= 1'b0;
    energy <= 1'b0;
    wait_sig(rpa, 1'b1);
    energy <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk(rpa, 1'b0);
    wr(5'h10, 16'h0000);
    energy <= 1'b0;
    repeat (10) @(posedge ref_clk);
    chk({rpa, pre}, 2'b00);
    energy <= 1'b1;
    wr(5'h10, 16'h0018);
    rd(5'h10, 16'h0018);
    wait_sig(smr, 1'b0);
    rd(5'h10, 16'h0010);
    wr(5'h10, 16'h0023);
    repeat (3) @(posedge ref_clk);
    chk({slp, mac_v, led}, 3'b100);
    wr(5'h10, 16'h0021);
    wait_sig(smr, 1'b1);
    wait_sig(smr, 1'b0);
    rd(5'h10, 16'h0021);
    // rx sampled at one edge must stand on the loop path just after it
    repeat (6)
    begin
      @(posedge ref_clk);
      d = rx_data;
      v = rx_valid;
      #1;
      chk({lo, loop_v, loop_d}, {1'b1, v, d});
    end
    // loop-out off: the same nibbles reach the mac path instead
    wr(5'h10, 16'h0020);
    repeat (6)
    begin
      @(posedge ref_clk);
      d = rx_data;
      v = rx_valid;
      #1;
      chk({loop_v, mac_v, mac_d}, {1'b0, v, d});
    end
    repeat (3) @(posedge ref_clk);
    print_verdict();
  end
endmodule
